// file: spr_pkg.sv
// Package for the stepper parameter register block
package spr_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_DECEL_SLOPE  = 8'h00;
  localparam logic [7:0] ADDR_THERM        = 8'h04;
  localparam logic [7:0] ADDR_ADC          = 8'h08;
  localparam logic [7:0] ADDR_OCD          = 8'h0c;
  localparam logic [7:0] ADDR_STALL        = 8'h10;
  localparam logic [7:0] ADDR_STEP_MODE    = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h1c;
  localparam logic [7:0] ADDR_DERIVED      = 8'h20;
  localparam logic [7:0] ADDR_CURRENT      = 8'h24;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_DECEL_SLOPE   = 8'h00;
  localparam logic [3:0] RST_THERM         = 4'h0;
  localparam logic [3:0] RST_OCD           = 4'h8;
  localparam logic [6:0] RST_STALL         = 7'h40;
  localparam logic [7:0] RST_STEP_MODE     = 8'h07;

  // ----------------------------------------
  // Field positions and codes
  // ----------------------------------------
  localparam int         SYNC_EN_BIT       = 7;
  localparam int         RSVD_BIT          = 3;
  localparam logic [7:0] STEP_MODE_WMASK   = 8'hf7;
  localparam logic [4:0] ADC_NOMINAL       = 5'h10;
  localparam logic [4:0] ADC_HI_SAT        = 5'h18;
  localparam logic [4:0] ADC_LO_SAT        = 5'h08;
  localparam logic [7:0] ELPOS_FIRST       = 8'h00;
  // Coefficients in 2.8 fixed point (256 = 1.0)
  localparam logic [9:0] COEF_ONE          = 10'h100;
  localparam logic [9:0] COEF_THERM_STEP   = 10'h008;
  localparam logic [9:0] COEF_SUP_MIN      = 10'h0a8;
  localparam logic [9:0] COEF_SUP_MAX      = 10'h1f8;
  // Thresholds in units of 31.25 mA
  localparam logic [7:0] OCD_UNIT          = 8'h0c;

  // Interrupt status bit positions
  localparam int         IRQ_REJECT        = 0;
  localparam int         IRQ_MODE_CHG      = 1;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    SPR_BEMF_OFF  = 2'b00,
    SPR_BEMF_LOW  = 2'b01,
    SPR_BEMF_ACC  = 2'b11,
    SPR_BEMF_DEC  = 2'b10
  } spr_bemf_t;

  typedef struct packed {
    logic       sync_en;
    logic [2:0] sync_sel;
    logic       rsvd;
    logic [2:0] step_sel;
  } spr_step_mode_t;

  typedef struct packed {
    logic       running;
    logic       accel;
    logic       decel;
    logic       above_int;
    logic [7:0] start_slope;
    logic [7:0] accel_slope;
  } spr_motion_t;

endpackage

// file: spr_regs.sv
// Stepper parameter registers with an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module spr_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire spr_pkg::spr_motion_t motion,
  input  wire logic              busy,
  input  wire logic              step_tick,
  input  wire logic [4:0]        adc_sample,
  input  wire logic              adc_sample_valid,
  output logic [7:0]             electrical_position,
  output logic [2:0]             step_sel,
  output logic [7:0]             bemf_slope,
  output logic                   bemf_enable,
  output logic [9:0]             therm_coef,
  output logic [9:0]             supply_coef,
  output logic [7:0]             overcurrent_threshold,
  output logic [7:0]             stall_threshold,
  output logic                   busy_sync_n,
  output logic                   command_rejected_flag,
  output logic                   irq
);
  import spr_pkg::*;

  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  logic rst_n;
  assign rst_n = rst_sync_ff;

  // ----------------------------------------
  // Write channel: address and data in either order
  // ----------------------------------------
  logic              aw_held_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic              w_held_ff;
  logic [31:0]       w_data_ff;
  logic [3:0]        w_strb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  logic              wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic              wr_lane0;
  assign wr_go    = (aw_held_ff || s_axi_awvalid) && (w_held_ff || s_axi_wvalid) && !bvalid_ff;
  assign wr_addr  = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
  assign wr_data  = w_held_ff ? w_data_ff : s_axi_wdata;
  assign wr_lane0 = w_held_ff ? w_strb_ff[0] : s_axi_wstrb[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
    end
  end

  function automatic logic known_addr(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    if (b == ADDR_DECEL_SLOPE) return 1'b1;
    else if (b == ADDR_THERM) return 1'b1;
    else if (b == ADDR_ADC) return 1'b1;
    else if (b == ADDR_OCD) return 1'b1;
    else if (b == ADDR_STALL) return 1'b1;
    else if (b == ADDR_STEP_MODE) return 1'b1;
    else if (b == ADDR_IRQ_STATUS) return 1'b1;
    else if (b == ADDR_IRQ_MASK) return 1'b1;
    else if (b == ADDR_DERIVED) return 1'b1;
    else if (b == ADDR_CURRENT) return 1'b1;
    else return 1'b0;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'b00;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= known_addr(wr_addr) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Only byte lane 0 carries register data; other lanes are ignored
  logic wr_en;
  assign wr_en = wr_go && wr_lane0;
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] r);
    return 8'(a) == r;
  endfunction

  // ----------------------------------------
  // Parameter registers
  // ----------------------------------------
  logic [7:0]     decel_final_slope_ff;
  logic [3:0]     thermal_drift_coefficient_ff;
  logic [3:0]     overcurrent_threshold_ff;
  logic [6:0]     stall_threshold_ff;
  spr_step_mode_t step_mode_ff;
  logic [4:0]     supply_adc_result_ff;
  logic           reject_dec;
  logic           reject_adc;
  logic           reject_step;

  assign reject_dec  = wr_en && hit(wr_addr, ADDR_DECEL_SLOPE) && motion.running;
  assign reject_adc  = wr_go && hit(wr_addr, ADDR_ADC);
  // Resolution changes mid-move would corrupt the position, so they are refused too
  assign reject_step = wr_en && hit(wr_addr, ADDR_STEP_MODE) && motion.running;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      decel_final_slope_ff <= RST_DECEL_SLOPE;
    end else if (wr_en && hit(wr_addr, ADDR_DECEL_SLOPE) && !reject_dec) begin
      decel_final_slope_ff <= wr_data[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thermal_drift_coefficient_ff <= RST_THERM;
      overcurrent_threshold_ff     <= RST_OCD;
      stall_threshold_ff           <= RST_STALL;
    end else if (wr_en) begin
      if (hit(wr_addr, ADDR_THERM)) thermal_drift_coefficient_ff <= wr_data[3:0];
      if (hit(wr_addr, ADDR_OCD)) overcurrent_threshold_ff <= wr_data[3:0];
      if (hit(wr_addr, ADDR_STALL)) stall_threshold_ff <= wr_data[6:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_mode_ff <= spr_step_mode_t'(RST_STEP_MODE);
    end else if (wr_en && hit(wr_addr, ADDR_STEP_MODE) && !reject_step) begin
      step_mode_ff <= spr_step_mode_t'(wr_data[7:0] & STEP_MODE_WMASK);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_adc_result_ff <= ADC_NOMINAL;
    end else if (adc_sample_valid) begin
      supply_adc_result_ff <= adc_sample;
    end
  end

  // ----------------------------------------
  // Derived values
  // ----------------------------------------
  assign therm_coef = COEF_ONE + COEF_THERM_STEP * 10'(thermal_drift_coefficient_ff);

  function automatic logic [9:0] sup_coef(input logic [4:0] c);
    // Linear through nominal: each code below 10000 down to 01000 adds ~0.121, above it up to 11000 subtracts 0.043
    if (c >= ADC_HI_SAT) return COEF_SUP_MIN;
    else if (c <= ADC_LO_SAT) return COEF_SUP_MAX;
    else if (c >= ADC_NOMINAL) return COEF_ONE - 10'(11 * (c - ADC_NOMINAL));
    else return COEF_ONE + 10'(31 * (ADC_NOMINAL - c));
  endfunction
  assign supply_coef = sup_coef(supply_adc_result_ff);

  assign overcurrent_threshold = OCD_UNIT * (8'(overcurrent_threshold_ff) + 8'h01);
  assign stall_threshold       = 8'(stall_threshold_ff) + 8'h01;
  assign step_sel              = step_mode_ff.step_sel;

  spr_bemf_t bemf_sel;
  always_comb begin
    if (motion.start_slope == 8'h00 && motion.accel_slope == 8'h00
        && decel_final_slope_ff == 8'h00) bemf_sel = SPR_BEMF_OFF;
    else if (!motion.above_int) bemf_sel = SPR_BEMF_LOW;
    else if (motion.decel) bemf_sel = SPR_BEMF_DEC;
    else bemf_sel = SPR_BEMF_ACC;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bemf_slope  <= 8'h00;
      bemf_enable <= 1'b0;
    end else begin
      bemf_enable <= bemf_sel != SPR_BEMF_OFF;
      case (bemf_sel)
        SPR_BEMF_LOW: bemf_slope <= motion.start_slope;
        SPR_BEMF_ACC: bemf_slope <= motion.accel_slope;
        SPR_BEMF_DEC: bemf_slope <= decel_final_slope_ff;
        default:      bemf_slope <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Electrical position and sync output
  // ----------------------------------------
  logic [2:0] last_sel_ff;
  logic       sel_changed;
  assign sel_changed = step_mode_ff.step_sel != last_sel_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_sel_ff         <= RST_STEP_MODE[2:0];
      electrical_position <= ELPOS_FIRST;
    end else begin
      last_sel_ff <= step_mode_ff.step_sel;
      if (sel_changed) electrical_position <= ELPOS_FIRST;
      else if (step_tick) electrical_position <= electrical_position + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_sync_n <= 1'b1;
    end else if (step_mode_ff.sync_en) begin
      busy_sync_n <= electrical_position[3'd7 - step_mode_ff.sync_sel];
    end else begin
      busy_sync_n <= !busy;
    end
  end

  // ----------------------------------------
  // Interrupts: sticky status, write one to clear
  // ----------------------------------------
  logic [1:0] irq_status_ff;
  logic [1:0] irq_mask_ff;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  assign irq_set = {sel_changed, reject_dec | reject_adc | reject_step};
  assign irq_clr = (wr_en && hit(wr_addr, ADDR_IRQ_STATUS)) ? wr_data[1:0] : 2'b00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_ff <= 2'b00;
      irq_mask_ff   <= 2'b00;
    end else begin
      // Set wins over a clear in the same cycle
      irq_status_ff <= (irq_status_ff & ~irq_clr) | irq_set;
      if (wr_en && hit(wr_addr, ADDR_IRQ_MASK)) irq_mask_ff <= wr_data[1:0];
    end
  end
  assign command_rejected_flag = irq_status_ff[IRQ_REJECT];
  assign irq                   = |(irq_status_ff & irq_mask_ff);

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic rvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff   <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff   <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (hit(s_axi_araddr, ADDR_DECEL_SLOPE)) s_axi_rdata <= {24'h0, decel_final_slope_ff};
      else if (hit(s_axi_araddr, ADDR_THERM)) s_axi_rdata <= {28'h0, thermal_drift_coefficient_ff};
      else if (hit(s_axi_araddr, ADDR_ADC)) s_axi_rdata <= {27'h0, supply_adc_result_ff};
      else if (hit(s_axi_araddr, ADDR_OCD)) s_axi_rdata <= {28'h0, overcurrent_threshold_ff};
      else if (hit(s_axi_araddr, ADDR_STALL)) s_axi_rdata <= {25'h0, stall_threshold_ff};
      else if (hit(s_axi_araddr, ADDR_STEP_MODE)) s_axi_rdata <= {24'h0, step_mode_ff};
      else if (hit(s_axi_araddr, ADDR_IRQ_STATUS)) s_axi_rdata <= {30'h0, irq_status_ff};
      else if (hit(s_axi_araddr, ADDR_IRQ_MASK)) s_axi_rdata <= {30'h0, irq_mask_ff};
      else if (hit(s_axi_araddr, ADDR_DERIVED)) s_axi_rdata <= {12'h0, therm_coef, supply_coef};
      else if (hit(s_axi_araddr, ADDR_CURRENT))
        s_axi_rdata <= {8'h0, electrical_position, overcurrent_threshold, stall_threshold};
      else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_dec_reject_keep: assert property (@(posedge clk) disable iff (!rst_n)
    reject_dec |=> decel_final_slope_ff == $past(decel_final_slope_ff) && command_rejected_flag)
    else $error("decel slope changed on rejected write");
  chk_adc_write_flag: assert property (@(posedge clk) disable iff (!rst_n)
    reject_adc |=> command_rejected_flag)
    else $error("adc write not flagged");
  chk_adc_follow: assert property (@(posedge clk) disable iff (!rst_n)
    adc_sample_valid |=> supply_adc_result_ff == $past(adc_sample))
    else $error("adc result not updated");
  chk_bemf_zero_off: assert property (@(posedge clk) disable iff (!rst_n)
    (motion.start_slope == 8'h00 && motion.accel_slope == 8'h00 && decel_final_slope_ff == 8'h00)
    |=> !bemf_enable)
    else $error("compensation active with zero slopes");
  chk_bemf_dec_pick: assert property (@(posedge clk) disable iff (!rst_n)
    (bemf_sel == SPR_BEMF_DEC) |=> bemf_slope == $past(decel_final_slope_ff))
    else $error("decel slope not selected");
  chk_therm_coef: assert property (@(posedge clk) disable iff (!rst_n)
    therm_coef == 10'h100 + {3'h0, thermal_drift_coefficient_ff, 3'h0})
    else $error("thermal coefficient wrong");
  chk_sup_sat: assert property (@(posedge clk) disable iff (!rst_n)
    supply_adc_result_ff >= 5'h18 |-> supply_coef == 10'h0a8)
    else $error("supply coefficient not saturated");
  chk_ocd_max: assert property (@(posedge clk) disable iff (!rst_n)
    overcurrent_threshold_ff == 4'hf |-> overcurrent_threshold == 8'hc0)
    else $error("overcurrent threshold wrong");
  chk_stall_dec: assert property (@(posedge clk) disable iff (!rst_n)
    stall_threshold == {1'b0, stall_threshold_ff} + 8'h01)
    else $error("stall threshold wrong");
  chk_rsvd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !step_mode_ff.rsvd)
    else $error("reserved step mode bit set");
  chk_elpos_reset: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(step_mode_ff.step_sel) |=> electrical_position == 8'h00)
    else $error("position not reset on mode change");
  chk_busy_low: assert property (@(posedge clk) disable iff (!rst_n)
    (!step_mode_ff.sync_en && busy) |=> !busy_sync_n)
    else $error("busy output not low");
  chk_sync_bit: assert property (@(posedge clk) disable iff (!rst_n)
    (step_mode_ff.sync_en && step_mode_ff.sync_sel == 3'h0)
    |=> busy_sync_n == $past(electrical_position[7]))
    else $error("sync bit wrong");
  cov_dec_reject: cover property (@(posedge clk) disable iff (!rst_n) reject_dec);
  cov_mode_change: cover property (@(posedge clk) disable iff (!rst_n) sel_changed);
  cov_irq: cover property (@(posedge clk) disable iff (!rst_n) irq);
  cov_sync_on: cover property (@(posedge clk) disable iff (!rst_n) step_mode_ff.sync_en);

endmodule
`default_nettype wire

// file: spr_host.sv
// Host model: AXI4-Lite master for the parameter registers
`timescale 1ns/1ps
`default_nettype none
module spr_host (
  input  wire logic        clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    // Step mode writes keep the reserved bit clear
    wdata <= (a == spr_pkg::ADDR_STEP_MODE) ? (d & 32'h0000_00f7) : d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Testbench for the stepper parameter registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import spr_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr, araddr, elpos, bslope, ocd, stall;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ben, bsn, rej, irq;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [2:0] ssel;
  logic [9:0] tcoef, scoef;
  spr_motion_t motion = '0;
  logic busy = 1'b0;
  logic tick_in = 1'b0;
  logic adc_v = 1'b0;
  logic [4:0] adc = 5'h10;
  logic [4:0] adc_tab [5] = '{5'h10, 5'h18, 5'h1f, 5'h08, 5'h00};
  logic [9:0] sup_tab [5] = '{10'h100, 10'h0a8, 10'h0a8, 10'h1f8, 10'h1f8};
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  spr_host u_spr_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  spr_regs u_spr_regs (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .motion(motion), .busy(busy), .step_tick(tick_in),
    .adc_sample(adc), .adc_sample_valid(adc_v), .electrical_position(elpos),
    .step_sel(ssel), .bemf_slope(bslope), .bemf_enable(ben), .therm_coef(tcoef),
    .supply_coef(scoef), .overcurrent_threshold(ocd), .stall_threshold(stall),
    .busy_sync_n(bsn), .command_rejected_flag(rej), .irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    u_spr_host.wr(a, v, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    u_spr_host.rd(a, d, r);
    chk(d, exp);
  endtask
  // Settle one or more edges so registered outputs have landed
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int n);
    @(posedge clk);
    tick_in <= 1'b1;
    repeat (n) @(posedge clk);
    tick_in <= 1'b0;
  endtask
  // ----------------------------------------
  // Hang guard
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rdc(ADDR_STEP_MODE, 32'h0000_0007);
    chk(ssel, 32'h0000_0007);
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_OCD, i * 15);
      wr(ADDR_STALL, i * 127);
      wr(ADDR_THERM, i * 15);
      cy(2);
      chk(ocd, (i * 15 + 1) * 12);
      chk(stall, i * 127 + 1);
      chk(tcoef, COEF_ONE + i * 15 * COEF_THERM_STEP);
    end
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      adc <= adc_tab[i];
      adc_v <= 1'b1;
      @(posedge clk);
      adc_v <= 1'b0;
      cy(2);
      chk(scoef, sup_tab[i]);
      rdc(ADDR_ADC, adc_tab[i]);
    end
    wr(ADDR_IRQ_MASK, 0);
    wr(ADDR_ADC, 32'h0000_001f);
    chk(r, 32'h0000_0000);
    rdc(ADDR_ADC, 0);
    chk(rej, 1);
    chk(irq, 0);
    wr(ADDR_IRQ_MASK, 3);
    cy(2);
    chk(irq, 1);
    wr(ADDR_IRQ_STATUS, 3);
    cy(2);
    chk(rej, 0);
    @(posedge clk);
    motion.running <= 1'b1;
    wr(ADDR_DECEL_SLOPE, 32'h0000_0055);
    chk(r, 32'h0000_0000);
    rdc(ADDR_DECEL_SLOPE, 0);
    chk(rej, 1);
    // Resolution writes while running are refused as well
    wr(ADDR_STEP_MODE, 32'h0000_0000);
    rdc(ADDR_STEP_MODE, 32'h0000_0007);
    @(posedge clk);
    motion <= '{running: 1'b0, accel: 1'b0, decel: 1'b1, above_int: 1'b1, default: '0};
    wr(ADDR_DECEL_SLOPE, 32'h0000_0033);
    cy(2);
    chk(bslope, 32'h0000_0033);
    chk(ben, 1);
    wr(ADDR_DECEL_SLOPE, 0);
    cy(2);
    chk(ben, 0);
    pulse(3);
    cy(2);
    chk(elpos, 3);
    wr(ADDR_STEP_MODE, 32'h0000_00f3);
    cy(2);
    chk(elpos, 0);
    chk(ssel, 3);
    rdc(ADDR_STEP_MODE, 32'h0000_00f3);
    pulse(1);
    cy(3);
    chk(bsn, 1);
    pulse(1);
    cy(3);
    chk(bsn, 0);
    // Source code 0 follows the top position bit; same resolution, no position reset
    wr(ADDR_STEP_MODE, 32'h0000_0083);
    cy(2);
    chk(bsn, 0);
    pulse(126);
    cy(3);
    chk(elpos, 32'h0000_0080);
    chk(bsn, 1);
    wr(ADDR_STEP_MODE, 32'h0000_0003);
    @(posedge clk);
    busy <= 1'b1;
    cy(3);
    chk(bsn, 0);
    @(posedge clk);
    busy <= 1'b0;
    cy(3);
    chk(bsn, 1);
    rdc(8'h3c, 0);
    chk(r, 2);
    complete_run();
  end
endmodule
`default_nettype wire
